/* design/ssr_pkg.sv */
// Shared constants, cycle codes and carriers for the burst SRAM cycle decoder.
// Assumes one clock; every user of these names writes ssr_pkg::name.
package ssr_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 19;          // Word address width
    localparam int MEM_WORDS = 2 ** ADDR_W; // Words in the array
    localparam int LANES     = 4;           // Byte lanes per word
    localparam int BYTE_W    = 8;           // Data bits per lane
    localparam int LANE_W    = BYTE_W + 1;  // Data bits plus parity bit
    localparam int DATA_W    = LANES * BYTE_W;
    localparam int BURST_W   = 2;           // Wrapping burst counter width
    localparam int BUF_DEPTH = 2;           // Write buffer entries

    // ------------------------------------------------------------------
    // Synchroniser and level bit positions
    // ------------------------------------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int LVL_SLEEP   = 0;
    localparam int LVL_ORDER   = 1;         // 1 = interleaved, 0 = linear
    localparam int LVL_W       = 2;

    // Reset values: awake, interleaved order
    localparam logic [LVL_W-1:0]             LEVEL_RST = 2'h2;
    localparam logic [SYNC_STAGES*LVL_W-1:0] SYNC_RST  = 6'h2a;
    localparam logic [BURST_W-1:0]           CNT_RST   = 2'h0;
    localparam logic [BURST_W-1:0]           CNT_STEP  = 2'h1;

    // Cycle outcome taken on a clock edge
    typedef enum logic [4:0] {
        SSR_DESEL  = 5'h01,
        SSR_SNOOZE = 5'h02,
        SSR_BEGIN  = 5'h04,
        SSR_CONT   = 5'h08,
        SSR_SUSP   = 5'h10
    } ssr_op_t;

    // One word of memory: lane-wise data with parity on top
    typedef logic [LANES-1:0][LANE_W-1:0] ssr_word_t;

    // Pending write: address, lanes to store, data
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lanes;
        ssr_word_t         word;
    } ssr_wr_word_t;

    // Registered state of the decoder apart from the array and the write buffer
    typedef struct packed {
        ssr_op_t                                 op;
        logic                                    wr;
        logic [ADDR_W-1:0]                       base;
        logic [BURST_W-1:0]                      cnt;
        ssr_word_t                               q;
        logic [SYNC_STAGES-1:0][LVL_W-1:0]       sync;
        logic [LVL_W-1:0]                        level;
    } ssr_state_t;

    localparam ssr_state_t STATE_RST = '{
        op:    SSR_DESEL,
        wr:    1'b0,
        base:  '0,
        cnt:   CNT_RST,
        q:     '0,
        sync:  SYNC_RST,
        level: LEVEL_RST
    };

endpackage

/* design/ssr_skid_buf.sv */
// Small FIFO with valid and ready on both sides; honest full and empty.
// Assumes both sides run on clk; reset_n is asynchronous, active low.
module ssr_skid_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } ssr_buf_state_t;

    ssr_buf_state_t st;
    ssr_buf_state_t next_st;
    logic           push;
    logic           pop;

    // Handshake terms
    assign in_ready  = (st.count != CW'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = st.slot[st.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.slot[st.wr_ptr] = in_data;
            next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
        end
        next_st.count = st.count + CW'(push) - CW'(pop);
    end

    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule

/* design/ssr_cycle_decode.sv */
// Cycle decoder, burst counter, byte-lane write and data pin control
// for a synchronous pipelined burst SRAM with its own storage array.
// Assumes all control, address and data pins change around clk edges;
// sleep_request and burst_order are asynchronous, output_enable_n acts
// without the clock.

module ssr_cycle_decode (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic [ssr_pkg::ADDR_W-1:0]   addr,
    input  wire logic                         primary_select_n,
    input  wire logic                         expansion_select_hi,
    input  wire logic                         expansion_select_lo_n,
    input  wire logic                         processor_addr_strobe_n,
    input  wire logic                         controller_addr_strobe_n,
    input  wire logic                         burst_advance_n,
    input  wire logic                         global_write_n,
    input  wire logic                         byte_write_enable_n,
    input  wire logic [ssr_pkg::LANES-1:0]    per_byte_write_n,
    input  wire logic                         burst_order,
    input  wire logic                         output_enable_n,
    input  wire logic                         sleep_request,
    input  wire logic [ssr_pkg::DATA_W-1:0]   data_in,
    input  wire logic [ssr_pkg::LANES-1:0]    parity_pins_in,
    output logic      [ssr_pkg::DATA_W-1:0]   data_out,
    output logic      [ssr_pkg::LANES-1:0]    parity_pins_out,
    output logic                              data_oe,
    output logic                              parity_pins_oe,
    output logic                              write_stall
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ssr_pkg::ssr_state_t                 st;
    ssr_pkg::ssr_state_t                 next_st;
    ssr_pkg::ssr_word_t                  mem [ssr_pkg::MEM_WORDS];
    ssr_pkg::ssr_word_t                  pin_word;
    ssr_pkg::ssr_word_t                  rd_word;
    ssr_pkg::ssr_wr_word_t               wr_in;
    ssr_pkg::ssr_wr_word_t               head;
    ssr_pkg::ssr_op_t                    op_now;
    logic                                wr_now;
    logic [ssr_pkg::ADDR_W-1:0]          acc_addr;
    logic [ssr_pkg::LANES-1:0]           lane_sel;
    logic                                sel;
    logic                                desel;
    logic                                w_low;
    logic                                sleep_on;
    logic                                order_il;
    logic                                access;
    logic                                buf_in_valid;
    logic                                buf_in_ready;
    logic                                buf_out_valid;
    logic                                buf_pop;
    logic                                read_live;

    assign sleep_on = st.level[ssr_pkg::LVL_SLEEP];
    assign order_il = st.level[ssr_pkg::LVL_ORDER];

    // Low two address bits for a burst step from the start address
    function automatic logic [ssr_pkg::BURST_W-1:0] burst_low(
        input logic [ssr_pkg::BURST_W-1:0] start,
        input logic [ssr_pkg::BURST_W-1:0] step,
        input logic                        il
    );
        burst_low = il ? (start ^ step) : (start + step);
    endfunction

    // ------------------------------------------------------------------
    // Pin packing per lane
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < ssr_pkg::LANES; gi++)
        begin : g_lane
            // Data byte plus parity form one lane
            assign pin_word[gi] = {parity_pins_in[gi],
                                   data_in[gi*ssr_pkg::BYTE_W +: ssr_pkg::BYTE_W]};
            assign data_out[gi*ssr_pkg::BYTE_W +: ssr_pkg::BYTE_W] =
                st.q[gi][ssr_pkg::BYTE_W-1:0];
            assign parity_pins_out[gi] = st.q[gi][ssr_pkg::BYTE_W];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Select and write decode
    // ------------------------------------------------------------------
    // All three selects active
    assign sel = !primary_select_n && expansion_select_hi && !expansion_select_lo_n;

    // Deselect combinations
    assign desel = (primary_select_n && !controller_addr_strobe_n) ||
                   (!primary_select_n && !(expansion_select_hi && !expansion_select_lo_n)
                    && (!processor_addr_strobe_n || !controller_addr_strobe_n));

    // Decoded write: global write, or byte enable with any lane
    assign w_low = !global_write_n ||
                   (!byte_write_enable_n && !(&per_byte_write_n));

    // Lanes stored by a write
    assign lane_sel = !global_write_n ? '1 :
                      (!byte_write_enable_n ? ~per_byte_write_n : '0);

    // ------------------------------------------------------------------
    // Cycle outcome for this edge
    // ------------------------------------------------------------------
    always_comb
    begin
        op_now   = ssr_pkg::SSR_SUSP;
        wr_now   = w_low;
        acc_addr = {st.base[ssr_pkg::ADDR_W-1:ssr_pkg::BURST_W],
                    burst_low(st.base[ssr_pkg::BURST_W-1:0], st.cnt, order_il)};
        if (sleep_on)
        begin
            op_now = ssr_pkg::SSR_SNOOZE;
            wr_now = 1'b0;
        end
        else if (desel)
        begin
            op_now = ssr_pkg::SSR_DESEL;
            wr_now = 1'b0;
        end
        else if (sel && !processor_addr_strobe_n)
        begin
            op_now   = ssr_pkg::SSR_BEGIN;
            wr_now   = 1'b0;
            acc_addr = addr;
        end
        else if (sel && !controller_addr_strobe_n)
        begin
            op_now   = ssr_pkg::SSR_BEGIN;
            wr_now   = w_low;
            acc_addr = addr;
        end
        else if (!burst_advance_n)
        begin
            op_now   = ssr_pkg::SSR_CONT;
            wr_now   = w_low;
            acc_addr = {st.base[ssr_pkg::ADDR_W-1:ssr_pkg::BURST_W],
                        burst_low(st.base[ssr_pkg::BURST_W-1:0],
                                  st.cnt + ssr_pkg::CNT_STEP, order_il)};
        end
    end

    assign access = (op_now == ssr_pkg::SSR_BEGIN) || (op_now == ssr_pkg::SSR_CONT) ||
                    (op_now == ssr_pkg::SSR_SUSP);

    // ------------------------------------------------------------------
    // Read path with forwarding of the oldest pending write
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_word = mem[acc_addr];
        for (int i = 0; i < ssr_pkg::LANES; i++)
        begin
            if (buf_out_valid && head.addr == acc_addr && head.lanes[i])
            begin
                rd_word[i] = head.word[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Write buffer: filled by write cycles, drained while awake
    // ------------------------------------------------------------------
    always_comb
    begin
        wr_in.addr  = acc_addr;
        wr_in.lanes = lane_sel;
        wr_in.word  = pin_word;
    end

    assign buf_in_valid = access && wr_now;
    assign buf_pop      = buf_out_valid && !sleep_on;
    assign write_stall  = !buf_in_ready;

    ssr_skid_buf #(
        .WIDTH ($bits(ssr_pkg::ssr_wr_word_t)),
        .DEPTH (ssr_pkg::BUF_DEPTH)
    ) u_wr_buf (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (wr_in),
        .out_valid (buf_out_valid),
        .out_ready (!sleep_on),
        .out_data  (head)
    );

    // Array store: only lanes flagged in the entry change
    always_ff @(posedge clk)
    begin
        if (buf_pop)
        begin
            for (int i = 0; i < ssr_pkg::LANES; i++)
            begin
                if (head.lanes[i])
                begin
                    mem[head.addr][i] <= head.word[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // Three-stage synchroniser; a level counts once stages two and three agree
        next_st.sync = {st.sync[1], st.sync[0], {burst_order, sleep_request}};
        for (int b = 0; b < ssr_pkg::LVL_W; b++)
        begin
            if (st.sync[2][b] == st.sync[1][b])
            begin
                next_st.level[b] = st.sync[2][b];
            end
        end
        next_st.op = op_now;
        next_st.wr = wr_now;
        if (op_now == ssr_pkg::SSR_BEGIN)
        begin
            next_st.base = addr;
            next_st.cnt  = ssr_pkg::CNT_RST;
        end
        else if (op_now == ssr_pkg::SSR_CONT)
        begin
            next_st.cnt = st.cnt + ssr_pkg::CNT_STEP;
        end
        if (access && !wr_now)
        begin
            next_st.q = rd_word;
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= ssr_pkg::STATE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Data pin direction
    // ------------------------------------------------------------------
    // Read cycle registered; enable pin gates without the clock
    assign read_live = (st.op == ssr_pkg::SSR_BEGIN || st.op == ssr_pkg::SSR_CONT ||
                        st.op == ssr_pkg::SSR_SUSP) && !st.wr;
    assign data_oe        = read_live && !output_enable_n && !sleep_on;
    assign parity_pins_oe = data_oe;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    desel_tristate_a: assert property (
        (!sleep_on && desel) |=> !data_oe && !parity_pins_oe)
        else $error("Pins driven after deselect");

    sleep_entry_a: assert property (
        sleep_request [*4] |=> sleep_on && !data_oe && !parity_pins_oe)
        else $error("Sleep not taken or pins driven in sleep");

    read_begin_a: assert property (
        (!sleep_on && sel && !processor_addr_strobe_n)
        |-> !buf_in_valid ##1 (!st.wr && (output_enable_n || sleep_on || data_oe)))
        else $error("Processor strobe did not start a read");

    write_begin_a: assert property (
        (!sleep_on && sel && processor_addr_strobe_n && !controller_addr_strobe_n && w_low)
        |-> buf_in_valid && wr_in.addr == addr ##1 !data_oe)
        else $error("Controller strobe write not taken");

    burst_step_a: assert property (
        (op_now == ssr_pkg::SSR_CONT && $past(op_now == ssr_pkg::SSR_BEGIN))
        |-> acc_addr[1:0] == (order_il ? ($past(addr[1:0]) ^ 2'h1)
                                       : ($past(addr[1:0]) + 2'h1)))
        else $error("Burst step address wrong");

    write_cont_a: assert property (
        (!sleep_on && !desel && controller_addr_strobe_n && !burst_advance_n && w_low
         && (processor_addr_strobe_n || primary_select_n))
        |-> buf_in_valid ##1 (st.cnt == $past(st.cnt) + 2'h1) && !data_oe)
        else $error("Write continue did not advance");

    suspend_hold_a: assert property (
        (!sleep_on && !desel && controller_addr_strobe_n && burst_advance_n
         && (processor_addr_strobe_n || primary_select_n))
        |=> st.cnt == $past(st.cnt) && st.base == $past(st.base))
        else $error("Suspend moved the burst address");

    lane_mask_a: assert property (
        buf_in_valid |-> wr_in.lanes == (!global_write_n ? {ssr_pkg::LANES{1'b1}}
                                                         : ~per_byte_write_n))
        else $error("Wrong lanes selected for write");

    read_data_a: assert property (
        (access && !wr_now) |=> st.q == $past(rd_word) && data_out[7:0] == $past(rd_word[0][7:0]))
        else $error("Read data not registered one clock later");

    write_mask_a: assert property (
        (st.wr && !output_enable_n) |-> !data_oe)
        else $error("Pins driven during write cycle");

    read_burst_c: cover property (
        op_now == ssr_pkg::SSR_BEGIN && !wr_now ##1 op_now == ssr_pkg::SSR_CONT [*3]);
    processor_addr_strobe_n_write_c: cover property (
        sel && !processor_addr_strobe_n ##1 op_now == ssr_pkg::SSR_SUSP && wr_now);
    sleep_c: cover property (sleep_on ##1 !sleep_on);
    stall_c: cover property (write_stall);

endmodule

/* test/ssr_bus_ctrl.sv */
// Controller model for the burst SRAM cycle decoder: drives every bus pin except burst_order.
// Assumes it shares clk with the decoder; the testbench calls its tasks.
module ssr_bus_ctrl (
    input  wire logic                  clk,
    output logic [ssr_pkg::ADDR_W-1:0] addr,
    output logic                       primary_select_n,
    output logic                       expansion_select_hi,
    output logic                       expansion_select_lo_n,
    output logic                       processor_addr_strobe_n,
    output logic                       controller_addr_strobe_n,
    output logic                       burst_advance_n,
    output logic                       global_write_n,
    output logic                       byte_write_enable_n,
    output logic [ssr_pkg::LANES-1:0]  per_byte_write_n,
    output logic                       output_enable_n,
    output logic [ssr_pkg::DATA_W-1:0] data_in,
    output logic [ssr_pkg::LANES-1:0]  parity_pins_in,
    output logic                       sleep_request
);
    timeunit 1ns;
    timeprecision 100ps;
    bit rude = 1'b0; // Keeps the enable low into a write when a test asks for it
    bit lo_off = 1'b0; // Drives the low expansion select inactive when a test asks for it

    // ------------------------------------------------------------------
    // Bus edges
    // ------------------------------------------------------------------
    // Set pins for one edge; idle data pins show the inverse of the last word
    task automatic set(input logic [4:0] ctl, input logic [5:0] wr,
                       input logic [18:0] a, input logic oe, input logic [35:0] d);
        logic w;
        // A selected processor-strobe begin is always a read, whatever the write pins say
        w = (ctl[4] || ctl[1]) && (!wr[5] || (!wr[4] && !(&wr[3:0])));
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
         primary_select_n, expansion_select_hi} = ctl;
        {global_write_n, byte_write_enable_n, per_byte_write_n} = wr;
        expansion_select_lo_n = lo_off;
        addr = a;
        output_enable_n = (rude || !w) ? oe : 1'b1;
        {parity_pins_in, data_in} = w ? d : ~{parity_pins_in, data_in};
    endtask

    // Pins change just after a rising edge and hold through the next one
    task automatic cyc(input logic [4:0] ctl, input logic [5:0] wr,
                       input logic [18:0] a, input logic oe, input logic [35:0] d);
        set(ctl, wr, a, oe, d);
        @(posedge clk);
        #2;
    endtask

    // Sleep changes only while the device is deselected
    task automatic nap(input logic z);
        cyc(5'h17, 6'h3f, '0, 1'b1, '0);
        sleep_request = z;
        repeat (4) cyc(5'h17, 6'h3f, '0, 1'b1, '0);
    endtask

    // Idle, awake and deselected from time zero
    initial
    begin
        sleep_request = 1'b0;
        data_in = '0;
        parity_pins_in = '0;
        set(5'h17, 6'h3f, '0, 1'b1, '0);
    end
endmodule

/* test/tb_ssr_cycle_decode.sv */
// Self-checking testbench for the burst SRAM cycle decoder.
// Assumes the package, the decoder and ssr_bus_ctrl are compiled first.
module tb_ssr_cycle_decode;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [4:0] IDLE = 5'h17, BEG_P = 5'h0d, BEG_C = 5'h15;
    localparam logic [4:0] CONT = 5'h19, SUSP = 5'h1d;
    logic clk = 1'b0, reset_n = 1'b0, burst_order = 1'b1;
    logic [18:0] addr;
    logic primary_select_n, expansion_select_hi, expansion_select_lo_n, sleep_request;
    logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
    logic global_write_n, byte_write_enable_n, output_enable_n;
    logic data_oe, parity_pins_oe, write_stall;
    logic [3:0] per_byte_write_n, parity_pins_in, parity_pins_out;
    logic [31:0] data_in, data_out;
    int err_total = 0, checks = 0;

    ssr_bus_ctrl u (.clk, .addr, .primary_select_n, .expansion_select_hi,
        .expansion_select_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
        .burst_advance_n, .global_write_n, .byte_write_enable_n, .per_byte_write_n,
        .output_enable_n, .data_in, .parity_pins_in, .sleep_request);
    ssr_cycle_decode dut (.clk, .reset_n, .addr, .primary_select_n, .expansion_select_hi,
        .expansion_select_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
        .burst_advance_n, .global_write_n, .byte_write_enable_n, .per_byte_write_n,
        .burst_order, .output_enable_n, .sleep_request, .data_in, .parity_pins_in,
        .data_out, .parity_pins_out, .data_oe, .parity_pins_oe, .write_stall);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // 40 MHz clock
    initial
    forever #12.5 clk = ~clk;

    function automatic logic [35:0] wd(input logic [7:0] x);
        return {x[3:0], {4{x}}};
    endfunction

    // Compare pin drive and, when driving, the word with parity
    task automatic chk(input logic [35:0] e, input logic oe);
        checks++;
        if (data_oe !== oe || parity_pins_oe !== oe || write_stall !== 1'b0 ||
            (oe && {parity_pins_out, data_out} !== e))
        begin
            err_total++;
            $display("ERROR %0t: got %h oe %b, want %h oe %b", $time,
                     {parity_pins_out, data_out}, data_oe, e, oe);
        end
    endtask

    // Write every lane through the controller strobe
    task automatic wr(input logic [18:0] a, input logic [35:0] d);
        u.cyc(BEG_C, 6'h1f, a, 1'b0, d);
    endtask

    // Read begun by the processor strobe, global write held low to be ignored
    task automatic rd(input logic [18:0] a, input logic [35:0] e);
        u.cyc(BEG_P, 6'h1f, a, 1'b0, '0);
        chk(e, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Every byte-lane code, then enable high with lanes low
    task automatic t_bytes;
        logic [35:0] e;
        for (int k = 0; k < 17; k++)
        begin
            e = 36'h0a5a5a5a5;
            wr(19'h7, e);
            u.cyc(BEG_C, (k < 16) ? {2'h2, k[3:0]} : 6'h30, 19'h7, 1'b0, 36'hf3c3c3c3c);
            for (int i = 0; i < 4; i++)
                if (k < 16 && !k[i]) {e[32+i], e[8*i+:8]} = {1'b1, 8'h3c};
            rd(19'h7, e);
        end
        $display("t_bytes done");
    endtask

    // Both burst orders from every start, then write continue and suspend
    task automatic t_burst;
        int j;
        for (int s = 0; s < 4; s++) wr(19'h20 + 19'(s), wd(8'(s)));
        for (int m = 0; m < 2; m++)
        begin
            burst_order = m[0];
            repeat (4) u.cyc(IDLE, 6'h3f, '0, 1'b1, '0);
            for (int s = 0; s < 4; s++)
            begin
                rd(19'h20 + 19'(s), wd(8'(s)));
                for (int k = 1; k < 4; k++)
                begin
                    j = m ? (s ^ k) : ((s + k) & 3);
                    u.cyc(CONT, 6'h3f, '0, 1'b0, '0);
                    chk(wd(8'(j)), 1'b1);
                end
                u.cyc(SUSP, 6'h3f, '0, 1'b0, '0);
                chk(wd(8'(j)), 1'b1);
            end
        end
        rd(19'h22, wd(8'h2));
        u.cyc(SUSP, 6'h1f, '0, 1'b0, wd(8'h9));
        chk('0, 1'b0);
        u.cyc(CONT, 6'h1f, '0, 1'b0, wd(8'ha));
        rd(19'h22, wd(8'h9));
        rd(19'h23, wd(8'ha));
        $display("t_burst done");
    endtask

    // Live output enable, masking in writes, deselect and sleep
    task automatic t_pins;
        rd(19'h20, wd(8'h0));
        u.output_enable_n = 1'b1;
        #1 chk('0, 1'b0);
        u.output_enable_n = 1'b0;
        #1 chk(wd(8'h0), 1'b1);
        u.rude = 1'b1;
        wr(19'h21, wd(8'h5));
        chk('0, 1'b0);
        u.rude = 1'b0;
        u.cyc(IDLE, 6'h3f, '0, 1'b0, '0);
        chk('0, 1'b0);
        rd(19'h21, wd(8'h5));
        u.cyc(5'h0c, 6'h3f, 19'h21, 1'b0, '0);
        chk('0, 1'b0);
        rd(19'h21, wd(8'h5));
        u.lo_off = 1'b1;
        u.cyc(BEG_P, 6'h3f, 19'h21, 1'b0, '0);
        chk('0, 1'b0);
        u.lo_off = 1'b0;
        u.nap(1'b1);
        u.cyc(BEG_P, 6'h3f, 19'h21, 1'b0, '0);
        chk('0, 1'b0);
        u.nap(1'b0);
        rd(19'h21, wd(8'h5));
        $display("t_pins done");
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Reset for 10 clocks, then the scenarios
    initial
    begin
        repeat (10) @(posedge clk);
        #2 reset_n = 1'b1;
        t_bytes();
        t_burst();
        t_pins();
        give_verdict();
    end

    // Watchdog well past the roughly 140 clocks the reset and scenarios need
    initial
    begin
        #500000;
        err_total++;
        give_verdict();
    end
endmodule
